// ---- verilog/uvps_map.svh ----
// Register offsets, field positions, reset values and time constants
// Assumes inclusion by the undervoltage stage top only
`ifndef UVPS_MAP_SVH
`define UVPS_MAP_SVH

// Timing
`define UVPS_CLK_PERIOD_PS  5000
`define UVPS_STAMP_RES_PS   1000000000
`define UVPS_TICK_PERIOD_MS 5

// Address map, stage block at stage * 0x100
`define UVPS_STAGE_STRIDE   12'h100
`define UVPS_GROUP_STRIDE   12'h010
`define UVPS_GRP_LEVELS     4'h0
`define UVPS_GRP_DELAY_CFG  4'h4
`define UVPS_GRP_FIXED_DLY  4'h8
`define UVPS_GRP_DIAL       4'hC
`define UVPS_STG_CTRL       8'h80
`define UVPS_STG_STATUS     8'h84
`define UVPS_STG_CNT_START  8'h88
`define UVPS_STG_CNT_TRIP   8'h8C
`define UVPS_STG_CNT_BLK    8'h90
`define UVPS_STG_PREFAULT   8'h94
`define UVPS_GLB_CTRL       12'h400
`define UVPS_GLB_TIME       12'h404

// Field positions
`define UVPS_F_THR_LSB      0
`define UVPS_F_BLK_LSB      16
`define UVPS_F_MODE_LSB     0
`define UVPS_F_EXPO_LSB     4
`define UVPS_F_BEHAV_LSB    0
`define UVPS_F_FORCE_LSB    4
`define UVPS_F_MAG_LSB      8
`define UVPS_F_CLR_LSB      16
`define UVPS_F_GROUP_LSB    0
`define UVPS_F_FORCE_EN     4
`define UVPS_F_WIRING       8

// Reset values, levels in 0.01 % of nominal, delays in 5 ms ticks
`define UVPS_RST_THR        16'h1770
`define UVPS_RST_BLK        16'h03E8
`define UVPS_RST_FIXED_DLY  16'h0008
`define UVPS_RST_DIAL       16'h000A
`define UVPS_RST_EXPO       3'h1
`define UVPS_HYST_NUM       17'h00067
`define UVPS_HYST_DEN       17'h00064

`endif

// ---- verilog/uvps_pkg.sv ----
// Types shared by the undervoltage stage top and its delay timer
// Assumes the map header is included by users for numeric constants
package uvps_pkg;
   typedef enum logic [1:0] {
      UVPS_DLY_INSTANT,
      UVPS_DLY_FIXED,
      UVPS_DLY_INVERSE,
      UVPS_DLY_SPARE
   } uvps_dly_mode_t;

   typedef enum logic [2:0] {
      UVPS_BH_NONE,
      UVPS_BH_ON,
      UVPS_BH_BLOCKED,
      UVPS_BH_TEST,
      UVPS_BH_TEST_BLOCKED,
      UVPS_BH_OFF
   } uvps_behav_t;

   typedef enum logic [1:0] {
      UVPS_FRC_NORMAL,
      UVPS_FRC_START,
      UVPS_FRC_TRIP,
      UVPS_FRC_BLOCKED
   } uvps_force_t;

   typedef enum logic [1:0] {
      UVPS_MAG_LINE,
      UVPS_MAG_PHASE,
      UVPS_MAG_CH3,
      UVPS_MAG_CH4
   } uvps_mag_t;

   typedef struct packed {
      logic [15:0] l12;
      logic [15:0] l23;
      logic [15:0] l31;
      logic [15:0] l1;
      logic [15:0] l2;
      logic [15:0] l3;
      logic [15:0] ch3;
      logic [15:0] ch4;
   } uvps_meas_t;

   typedef struct packed {
      logic start;
      logic trip;
      logic blocked;
   } uvps_out_t;

   typedef struct packed {
      logic start_on;
      logic start_off;
      logic trip_on;
      logic trip_off;
      logic blk_on;
      logic blk_off;
   } uvps_evt_t;
endpackage

// ---- verilog/uvps_timer.sv ----
// Operate-delay timer of one stage: instant, fixed or inverse time
// Assumes tick pulses once per 5 ms and run holds while START is on
`timescale 1ns/10ps
module uvps_timer (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // Control
   input  wire logic                    tick,
   input  wire logic                    run,
   input  wire uvps_pkg::uvps_dly_mode_t mode,
   input  wire logic [15:0]             fixed_dly,
   input  wire logic [15:0]             dial,
   input  wire logic [2:0]              expo,
   input  wire logic [15:0]             meas,
   input  wire logic [15:0]             thr,
   // Result
   output logic                         expired
);
   logic [15:0] cnt_ff;
   logic [47:0] acc_ff;
   logic [31:0] ratio;
   logic [31:0] pw;
   logic [31:0] prod;

   // Ratio measured/threshold in Q16, clipped just below one
   always_comb begin
      ratio = 32'h0000FFFF;
      if (thr != 16'h0000 && meas < thr) begin
         ratio = {meas, 16'h0000} / {16'h0000, thr};
      end
      pw = ratio;
      prod = 32'h0;
      for (int i = 1; i < 8; i++) begin
         prod = 32'((64'(pw) * 64'(ratio)) >> 16);
         if (3'(i) < expo) begin
            pw = prod;
         end
      end
   end

   // fixed delay count
   // Run only means something on the tick; between ticks it may glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 16'h0000;
      end else if (tick) begin
         if (!run) begin
            cnt_ff <= 16'h0000;
         end else if (cnt_ff != 16'hFFFF) begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end
   end

   // integrate one minus ratio power; trips at dial/(1-r^a)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= 48'h0;
      end else if (tick) begin
         if (!run) begin
            acc_ff <= 48'h0;
         end else begin
            acc_ff <= acc_ff + 48'(32'h00010000 - pw);
         end
      end
   end

   always_comb begin
      unique case (mode)
         uvps_pkg::UVPS_DLY_INSTANT: expired = run;
         uvps_pkg::UVPS_DLY_FIXED:   expired = run && cnt_ff >= fixed_dly;
         uvps_pkg::UVPS_DLY_INVERSE:
            expired = run && acc_ff >= {16'h0000, dial, 16'h0000};
         default:                    expired = run;
      endcase
   end
endmodule

// ---- verilog/uvps_top.sv ----
// Four undervoltage protection stages with APB settings and status
// Assumes meas_tick pulses once per 5 ms with fresh RMS values
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "uvps_map.svh"

module uvps_top #(
   parameter int NSTAGE     = 4,
   parameter int NGROUP     = 8,
   parameter int CYC_PER_MS = `UVPS_STAMP_RES_PS / `UVPS_CLK_PERIOD_PS
) (
   // APB slave
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Measurements
   input  wire logic                        meas_tick,
   input  wire uvps_pkg::uvps_meas_t        meas,
   input  wire logic [NSTAGE-1:0]           ext_block,
   // Stage outputs and events
   output uvps_pkg::uvps_out_t [NSTAGE-1:0] stage_out,
   output uvps_pkg::uvps_evt_t [NSTAGE-1:0] evt,
   output logic [31:0]                      evt_stamp_ms
);
   localparam int GW = $clog2(NGROUP);

   // Setting groups
   logic [15:0]             thr_ff   [NSTAGE][NGROUP];
   logic [15:0]             blk_ff   [NSTAGE][NGROUP];
   uvps_pkg::uvps_dly_mode_t mode_ff [NSTAGE][NGROUP];
   logic [2:0]              expo_ff  [NSTAGE][NGROUP];
   logic [15:0]             fdly_ff  [NSTAGE][NGROUP];
   logic [15:0]             dial_ff  [NSTAGE][NGROUP];
   // Static per stage and global
   uvps_pkg::uvps_behav_t   behav_ff [NSTAGE];
   uvps_pkg::uvps_force_t   force_ff [NSTAGE];
   uvps_pkg::uvps_mag_t     mag_ff   [NSTAGE];
   logic [2:0]              clr_ff   [NSTAGE];
   logic [GW-1:0]           group_ff;
   logic                    force_en_ff;
   logic                    wiring_ff;
   // Time stamp
   logic [31:0]             ms_cnt_ff;
   logic [31:0]             stamp_ff;
   // Stage state
   logic [NSTAGE-1:0]       pickup_ff;
   logic [NSTAGE-1:0]       lvblk_ff;
   uvps_pkg::uvps_out_t [NSTAGE-1:0] out_ff;
   uvps_pkg::uvps_evt_t [NSTAGE-1:0] evt_ff;
   logic [15:0]             cnt_st_ff [NSTAGE];
   logic [15:0]             cnt_tr_ff [NSTAGE];
   logic [15:0]             cnt_bk_ff [NSTAGE];
   logic [15:0]             pref_ff   [NSTAGE];

   logic        wr;
   logic        stage_hit;
   logic        grp_hit;
   logic [1:0]  a_stage;
   logic [GW-1:0] a_group;
   logic [3:0]  a_field;
   logic [7:0]  a_low;
   logic        mapped;

   assign wr        = psel && penable && pwrite;
   assign a_stage   = paddr[9:8];
   assign a_low     = paddr[7:0];
   assign a_group   = paddr[4+GW-1:4];
   assign a_field   = paddr[3:0];
   assign stage_hit = paddr[11:10] == 2'b00 && 32'(a_stage) < NSTAGE;
   assign grp_hit   = stage_hit && !paddr[7];
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;
   assign stage_out = out_ff;
   assign evt       = evt_ff;
   assign evt_stamp_ms = stamp_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < NSTAGE; s++) begin
            for (int g = 0; g < NGROUP; g++) begin
               thr_ff[s][g]  <= `UVPS_RST_THR;
               blk_ff[s][g]  <= `UVPS_RST_BLK;
               mode_ff[s][g] <= uvps_pkg::UVPS_DLY_FIXED;
               expo_ff[s][g] <= `UVPS_RST_EXPO;
               fdly_ff[s][g] <= `UVPS_RST_FIXED_DLY;
               dial_ff[s][g] <= `UVPS_RST_DIAL;
            end
         end
      end else if (wr && grp_hit) begin
         unique case (a_field)
            `UVPS_GRP_LEVELS: begin
               thr_ff[a_stage][a_group] <= pwdata[`UVPS_F_THR_LSB +: 16];
               blk_ff[a_stage][a_group] <= pwdata[`UVPS_F_BLK_LSB +: 16];
            end
            `UVPS_GRP_DELAY_CFG: begin
               mode_ff[a_stage][a_group] <= uvps_pkg::uvps_dly_mode_t'(
                  pwdata[`UVPS_F_MODE_LSB +: 2]);
               expo_ff[a_stage][a_group] <= pwdata[`UVPS_F_EXPO_LSB +: 3];
            end
            `UVPS_GRP_FIXED_DLY: fdly_ff[a_stage][a_group] <= pwdata[15:0];
            `UVPS_GRP_DIAL:      dial_ff[a_stage][a_group] <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // static stage controls, clear bits act for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < NSTAGE; s++) begin
            behav_ff[s] <= uvps_pkg::UVPS_BH_ON;
            force_ff[s] <= uvps_pkg::UVPS_FRC_NORMAL;
            mag_ff[s]   <= uvps_pkg::UVPS_MAG_LINE;
            clr_ff[s]   <= 3'h0;
         end
      end else begin
         for (int s = 0; s < NSTAGE; s++) begin
            clr_ff[s] <= 3'h0;
         end
         if (wr && stage_hit && a_low == `UVPS_STG_CTRL) begin
            behav_ff[a_stage] <= uvps_pkg::uvps_behav_t'(
               pwdata[`UVPS_F_BEHAV_LSB +: 3]);
            force_ff[a_stage] <= uvps_pkg::uvps_force_t'(
               pwdata[`UVPS_F_FORCE_LSB +: 2]);
            mag_ff[a_stage]   <= uvps_pkg::uvps_mag_t'(
               pwdata[`UVPS_F_MAG_LSB +: 2]);
            clr_ff[a_stage]   <= pwdata[`UVPS_F_CLR_LSB +: 3];
         end
      end
   end

   // Global controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         group_ff    <= '0;
         force_en_ff <= 1'b0;
         wiring_ff   <= 1'b0;
      end else if (wr && paddr == `UVPS_GLB_CTRL) begin
         group_ff    <= pwdata[`UVPS_F_GROUP_LSB +: GW];
         force_en_ff <= pwdata[`UVPS_F_FORCE_EN];
         wiring_ff   <= pwdata[`UVPS_F_WIRING];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_ff <= 32'h0;
         stamp_ff  <= 32'h0;
      end else if (ms_cnt_ff == 32'(CYC_PER_MS - 1)) begin
         ms_cnt_ff <= 32'h0;
         stamp_ff  <= stamp_ff + 32'h1;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 32'h1;
      end
   end

   // APB read mux; answers in the access cycle
   always_comb begin
      prdata = 32'h0;
      mapped = 1'b1;
      if (grp_hit) begin
         unique case (a_field)
            `UVPS_GRP_LEVELS:
               prdata = {blk_ff[a_stage][a_group], thr_ff[a_stage][a_group]};
            `UVPS_GRP_DELAY_CFG:
               prdata = {25'h0, expo_ff[a_stage][a_group], 2'h0,
                         mode_ff[a_stage][a_group]};
            `UVPS_GRP_FIXED_DLY: prdata = {16'h0, fdly_ff[a_stage][a_group]};
            `UVPS_GRP_DIAL:      prdata = {16'h0, dial_ff[a_stage][a_group]};
            default:             mapped = 1'b0;
         endcase
      end else if (stage_hit) begin
         unique case (a_low)
            `UVPS_STG_CTRL:
               prdata = {22'h0, mag_ff[a_stage], 2'h0, force_ff[a_stage],
                         1'b0, behav_ff[a_stage]};
            `UVPS_STG_STATUS:
               prdata = {27'h0, pickup_ff[a_stage], lvblk_ff[a_stage],
                         out_ff[a_stage]};
            `UVPS_STG_CNT_START: prdata = {16'h0, cnt_st_ff[a_stage]};
            `UVPS_STG_CNT_TRIP:  prdata = {16'h0, cnt_tr_ff[a_stage]};
            `UVPS_STG_CNT_BLK:   prdata = {16'h0, cnt_bk_ff[a_stage]};
            `UVPS_STG_PREFAULT:  prdata = {16'h0, pref_ff[a_stage]};
            default:             mapped = 1'b0;
         endcase
      end else if (paddr == `UVPS_GLB_CTRL) begin
         prdata = {23'h0, wiring_ff, 3'h0, force_en_ff, {(4-GW){1'b0}},
                   group_ff};
      end else if (paddr == `UVPS_GLB_TIME) begin
         prdata = stamp_ff;
      end else begin
         mapped = 1'b0;
      end
   end

   for (genvar s = 0; s < NSTAGE; s++) begin : g_stage
      logic [15:0]  v0;
      logic [15:0]  v1;
      logic [15:0]  v2;
      logic [15:0]  vmin;
      logic         src_ok;
      logic [15:0]  thr;
      logic [15:0]  blk;
      logic [16:0]  rel_lvl;
      logic         any_low;
      logic         all_rel;
      logic         all_above;
      logic         nxt_pickup;
      logic         nxt_lvblk;
      logic         blk_any;
      logic         off;
      logic         expired;
      uvps_pkg::uvps_out_t nxt_out;
      uvps_pkg::uvps_out_t frc_out;
      logic [15:0]  hist_ff [8];
      logic [17:0]  avg_sum;

      assign thr = thr_ff[s][group_ff];
      assign blk = blk_ff[s][group_ff];

      always_comb begin
         src_ok = 1'b1;
         unique case (mag_ff[s])
            uvps_pkg::UVPS_MAG_LINE: begin
               v0 = meas.l12;
               v1 = meas.l23;
               v2 = meas.l31;
            end
            uvps_pkg::UVPS_MAG_PHASE: begin
               v0 = meas.l1;
               v1 = meas.l2;
               v2 = meas.l3;
            end
            uvps_pkg::UVPS_MAG_CH3: begin
               v0 = meas.ch3;
               v1 = meas.ch3;
               v2 = meas.ch3;
               src_ok = wiring_ff;
            end
            uvps_pkg::UVPS_MAG_CH4: begin
               v0 = meas.ch4;
               v1 = meas.ch4;
               v2 = meas.ch4;
            end
         endcase
      end

      assign vmin    = (v0 < v1 ? (v0 < v2 ? v0 : v2) : (v1 < v2 ? v1 : v2));
      // release level 103 % of threshold
      assign rel_lvl = 17'((34'({1'b0, thr}) * 34'(`UVPS_HYST_NUM))
                           / 34'(`UVPS_HYST_DEN));
      assign any_low   = src_ok && vmin < thr;
      assign all_rel   = {1'b0, vmin} >= rel_lvl;
      assign all_above = vmin > thr;
      assign nxt_pickup = pickup_ff[s] ? (src_ok && !all_rel) : any_low;

      always_comb begin
         nxt_lvblk = lvblk_ff[s];
         if (blk == 16'h0000 || !src_ok) begin
            nxt_lvblk = 1'b0;
         end else if (vmin < blk) begin
            nxt_lvblk = 1'b1;
         end else if (all_above) begin
            nxt_lvblk = 1'b0;
         end
      end

      // block sources, external sampled on the tick
      assign off     = behav_ff[s] == uvps_pkg::UVPS_BH_OFF;
      assign blk_any = ext_block[s] || nxt_lvblk
                       || behav_ff[s] == uvps_pkg::UVPS_BH_BLOCKED
                       || behav_ff[s] == uvps_pkg::UVPS_BH_TEST_BLOCKED;

      uvps_timer u_timer (
         .pclk      (pclk),
         .presetn   (presetn),
         .tick      (meas_tick),
         .run       (nxt_out.start),
         .mode      (mode_ff[s][group_ff]),
         .fixed_dly (fdly_ff[s][group_ff]),
         .dial      (dial_ff[s][group_ff]),
         .expo      (expo_ff[s][group_ff]),
         .meas      (vmin),
         .thr       (thr),
         .expired   (expired)
      );

      always_comb begin
         // START needs pick-up with no block
         nxt_out.start   = !off && nxt_pickup && !blk_any;
         nxt_out.blocked = !off && nxt_pickup && blk_any;
         // issued TRIP stays until pick-up releases
         nxt_out.trip    = !off && nxt_pickup
                           && (out_ff[s].trip || (nxt_out.start && expired));
         // override only while forcing is enabled
         frc_out = nxt_out;
         if (force_en_ff) begin
            unique case (force_ff[s])
               uvps_pkg::UVPS_FRC_NORMAL:  frc_out = nxt_out;
               uvps_pkg::UVPS_FRC_START:   frc_out = 3'b100;
               uvps_pkg::UVPS_FRC_TRIP:    frc_out = 3'b110;
               uvps_pkg::UVPS_FRC_BLOCKED: frc_out = 3'b001;
            endcase
         end
      end

      // stage state advances only on the measurement tick
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pickup_ff[s] <= 1'b0;
            lvblk_ff[s]  <= 1'b0;
            out_ff[s]    <= '0;
         end else if (meas_tick) begin
            pickup_ff[s] <= nxt_pickup && !off;
            lvblk_ff[s]  <= nxt_lvblk;
            out_ff[s]    <= frc_out;
         end
      end

      // ON and OFF event pulses, same cycle for instant trip
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            evt_ff[s] <= '0;
         end else if (meas_tick) begin
            evt_ff[s].start_on  <= frc_out.start && !out_ff[s].start;
            evt_ff[s].start_off <= !frc_out.start && out_ff[s].start;
            evt_ff[s].trip_on   <= frc_out.trip && !out_ff[s].trip;
            evt_ff[s].trip_off  <= !frc_out.trip && out_ff[s].trip;
            evt_ff[s].blk_on    <= frc_out.blocked && !out_ff[s].blocked;
            evt_ff[s].blk_off   <= !frc_out.blocked && out_ff[s].blocked;
         end else begin
            evt_ff[s] <= '0;
         end
      end

      // counters, an event in the clear cycle still counts
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_st_ff[s] <= 16'h0000;
            cnt_tr_ff[s] <= 16'h0000;
            cnt_bk_ff[s] <= 16'h0000;
         end else begin
            if (evt_ff[s].start_on) begin
               cnt_st_ff[s] <= (clr_ff[s][0] ? 16'h0000 : cnt_st_ff[s])
                               + 16'h0001;
            end else if (clr_ff[s][0]) begin
               cnt_st_ff[s] <= 16'h0000;
            end
            if (evt_ff[s].trip_on) begin
               cnt_tr_ff[s] <= (clr_ff[s][1] ? 16'h0000 : cnt_tr_ff[s])
                               + 16'h0001;
            end else if (clr_ff[s][1]) begin
               cnt_tr_ff[s] <= 16'h0000;
            end
            if (evt_ff[s].blk_on) begin
               cnt_bk_ff[s] <= (clr_ff[s][2] ? 16'h0000 : cnt_bk_ff[s])
                               + 16'h0001;
            end else if (clr_ff[s][2]) begin
               cnt_bk_ff[s] <= 16'h0000;
            end
         end
      end

      // older four ticks form the window ending 25 ms back
      assign avg_sum = 18'(hist_ff[4]) + 18'(hist_ff[5])
                       + 18'(hist_ff[6]) + 18'(hist_ff[7]);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
               hist_ff[i] <= 16'h0000;
            end
            pref_ff[s] <= 16'h0000;
         end else if (meas_tick) begin
            hist_ff[0] <= vmin;
            for (int i = 1; i < 8; i++) begin
               hist_ff[i] <= hist_ff[i-1];
            end
            if ((frc_out.start && !out_ff[s].start)
                || (frc_out.trip && !out_ff[s].trip)) begin
               pref_ff[s] <= avg_sum[17:2];
            end
         end
      end
   end
endmodule

// ---- verif/uvps_front_end.sv ----
// Front end model: one RMS set per 5 ms tick
// Assumes the bench holds level; every channel carries it
`timescale 1ns/10ps
module uvps_front_end #(
   parameter int PERIOD = 50
) (
   // Clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // Bench and design sides
   input  wire logic [15:0]     level,
   output logic                 meas_tick,
   output uvps_pkg::uvps_meas_t meas
);
   int cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         meas_tick <= 1'b0;
         meas <= '0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         meas_tick <= (cnt == PERIOD - 1);
         // Garbage off tick, so stray sampling shows
         meas <= {8{(cnt == PERIOD - 1) ? level : ~level}};
      end
   end
endmodule

// ---- verif/uvps_monitor.sv ----
// Checker of stage zero outputs and event pulses
// Assumes bind to uvps_top, one clock domain
`timescale 1ns/10ps
module uvps_monitor #(
   parameter int NSTAGE = 4
) (
   input wire logic                             pclk,
   input wire logic                             presetn,
   input wire logic                             meas_tick,
   input wire uvps_pkg::uvps_out_t [NSTAGE-1:0] stage_out,
   input wire uvps_pkg::uvps_evt_t [NSTAGE-1:0] evt,
   input wire logic [31:0]                      evt_stamp_ms
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_evt_tick_lag: assert property (|evt[0] |-> $past(meas_tick))
      else $error("event not one cycle after tick");
   a_start_on_edge: assert property (evt[0].start_on |->
      stage_out[0].start && !$past(stage_out[0].start))
      else $error("start on without start rise");
   a_start_off_edge: assert property (evt[0].start_off |->
      !stage_out[0].start && $past(stage_out[0].start))
      else $error("start off without start fall");
   a_trip_on_edge: assert property (evt[0].trip_on |->
      stage_out[0].trip && !$past(stage_out[0].trip))
      else $error("trip on without trip rise");
   a_blk_on_edge: assert property (evt[0].blk_on |->
      stage_out[0].blocked && !$past(stage_out[0].blocked))
      else $error("block on without block rise");
   a_start_blk_excl: assert property
      (!(stage_out[0].start && stage_out[0].blocked))
      else $error("start and blocked together");
   a_evt_one_cycle: assert property (|evt[0] |=> !(|evt[0]))
      else $error("event longer than one cycle");
   a_stamp_steps: assert property (evt_stamp_ms == $past(evt_stamp_ms)
      || evt_stamp_ms == $past(evt_stamp_ms) + 32'h1)
      else $error("stamp jumped");
endmodule

bind uvps_top uvps_monitor #(.NSTAGE(NSTAGE)) u_uvps_monitor (
   .pclk(pclk), .presetn(presetn), .meas_tick(meas_tick),
   .stage_out(stage_out), .evt(evt), .evt_stamp_ms(evt_stamp_ms));

// ---- verif/uvps_top_tb.sv ----
// Bench for stage zero: APB settings, ticks, outputs, events
// Assumes the front end model ticks every 50 cycles
`timescale 1ns/10ps
module uvps_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        meas_tick, er;
   logic [11:0] paddr;
   logic [15:0] level;
   logic [3:0]  ext_block;
   logic [31:0] pwdata, prdata, rd, evt_stamp_ms;
   int          errors, comparisons;
   uvps_pkg::uvps_meas_t      meas;
   uvps_pkg::uvps_out_t [3:0] stage_out;
   uvps_pkg::uvps_evt_t [3:0] evt;

   uvps_top #(.CYC_PER_MS(10)) u_uvps_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .meas_tick(meas_tick), .meas(meas),
      .ext_block(ext_block), .stage_out(stage_out), .evt(evt),
      .evt_stamp_ms(evt_stamp_ms));
   uvps_front_end #(.PERIOD(50)) u_uvps_front_end (.pclk(pclk),
      .presetn(presetn), .level(level), .meas_tick(meas_tick),
      .meas(meas));

   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("unexpected %s exp %h seen %h", n, x, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic rdy;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Settled values are taken mid-cycle; the next rising edge ends it
      do begin
         @(negedge pclk);
         rd = prdata;
         er = pslverr;
         rdy = pready;
         @(posedge pclk);
      end while (rdy !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait n ticks, then let outputs and events settle
   task tk(input int n);
      @(posedge pclk);
      repeat (n) begin
         @(negedge pclk);
         while (meas_tick !== 1'b1) @(negedge pclk);
      end
      repeat (3) @(posedge pclk);
   endtask
   task final_report;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task s_reset;
      apb(1'b0, 12'h000, 32'h0);
      chk("levels", rd, 32'h03E81770);
      apb(1'b0, 12'h080, 32'h0);
      chk("ctrl", rd, 32'h00000001);
      apb(1'b0, 12'h7FC, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      chk("unmapped data", rd, 32'h0);
   endtask
   task s_instant;
      apb(1'b1, 12'h004, 32'h0);
      level <= 16'h1388;
      for (int i = 0; i < 200 && evt[0].start_on !== 1'b1; i++)
         @(negedge pclk);
      chk("trip with start", {31'h0, evt[0].trip_on}, 32'h1);
      tk(1);
      chk("out", 32'(stage_out[0]), 32'h6);
      level <= 16'h17D4;
      tk(1);
      chk("hyst hold", 32'(stage_out[0]), 32'h6);
      level <= 16'h1838;
      tk(1);
      chk("released", 32'(stage_out[0]), 32'h0);
      apb(1'b0, 12'h088, 32'h0);
      chk("start count", rd, 32'h1);
      apb(1'b1, 12'h080, 32'h00010001);
      apb(1'b0, 12'h088, 32'h0);
      chk("cleared", rd, 32'h0);
   endtask
   task s_fixed;
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b1, 12'h008, 32'h3);
      level <= 16'h1388;
      tk(3);
      chk("before delay", 32'(stage_out[0]), 32'h4);
      tk(1);
      chk("after delay", 32'(stage_out[0]), 32'h6);
      level <= 16'h1B58;
      tk(1);
   endtask
   task s_block;
      ext_block <= 4'h1;
      level <= 16'h1388;
      tk(1);
      chk("ext blocked", 32'(stage_out[0]), 32'h1);
      ext_block <= 4'h0;
      level <= 16'h1B58;
      tk(1);
      level <= 16'h1388;
      tk(1);
      ext_block <= 4'h1;
      tk(3);
      chk("start dropped", {31'h0, stage_out[0].start}, 32'h0);
      chk("no trip", {31'h0, stage_out[0].trip}, 32'h0);
      ext_block <= 4'h0;
      level <= 16'h1B58;
      tk(1);
   endtask
   task s_lowv;
      level <= 16'h01F4;
      tk(1);
      level <= 16'h1388;
      tk(4);
      chk("no trip", {31'h0, stage_out[0].trip}, 32'h0);
      apb(1'b0, 12'h084, 32'h0);
      chk("low block", {31'h0, rd[3]}, 32'h1);
      level <= 16'h17D4;
      tk(1);
      apb(1'b0, 12'h084, 32'h0);
      chk("low block off", {31'h0, rd[3]}, 32'h0);
   endtask
   task s_force;
      level <= 16'h1B58;
      apb(1'b1, 12'h400, 32'h00000010);
      apb(1'b1, 12'h080, 32'h00000021);
      tk(1);
      chk("forced trip", 32'(stage_out[0]), 32'h6);
      apb(1'b1, 12'h400, 32'h0);
      tk(1);
      chk("force off", 32'(stage_out[0]), 32'h0);
      apb(1'b1, 12'h010, 32'h03E81F40);
      apb(1'b1, 12'h400, 32'h00000001);
      tk(1);
      chk("group one", 32'(stage_out[0]), 32'h4);
      apb(1'b1, 12'h400, 32'h0);
      tk(1);
      chk("group zero", 32'(stage_out[0]), 32'h0);
   endtask

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      final_report;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      level = 16'h1B58;
      ext_block = 4'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      s_reset;
      s_instant;
      s_fixed;
      s_block;
      s_lowv;
      s_force;
      final_report;
   end
endmodule
